// ===== swcd_top.sv
// Purpose: decode setting switches into network identity, address, radio channel,
//   encryption and input-to-output trigger behaviour
// Assumes: switches and input channels are asynchronous pins; linkUp and coordEncrypt
//   come from radio logic on ref_clk
// Notes: registers on Avalon-MM; every access answers on its second cycle
//
// How it works
// RQ1: normal mode: stored identity, rotary channel, switch address
// RQ2: setup mode forces identity 0x3FFF, rotary channel
// RQ3: setup mode forces node address 0x0020
// RQ4: level mode: any input high drives outputs high
// RQ5: pulse mode: input rising edge inverts outputs once
// RQ6: encryption switch on selects 128-bit cipher
// RQ7: coordinator's encryption setting governs the whole group
// RQ8: five switches form address, first is msb
// RQ9: installer sets exactly one coordinator per network
// RQ10: installer keeps node addresses unique per group
// RQ11: rotary 0..F maps to 2405..2480 MHz ascending
// RQ12: installer sets identical rotary position network-wide
// RQ13: green indicator lights only once link established
// RQ14: switches sampled once after reset release
`timescale 1ns/100ps
module swcd_top #(
	parameter int CH = 8 // input and output channel count, at most 16
) (
	// clock, reset, enable
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic ce,
	// setting switches, on = 1
	input wire logic modeSw,
	input wire logic trigSw,
	input wire logic encSw,
	input wire logic [swcd_pkg::ADDR_SW_W-1:0] addrSw,
	input wire logic [swcd_pkg::ROT_SW_W-1:0] rotarySw,
	// field channels
	input wire logic [CH-1:0] inputChannel,
	output logic [CH-1:0] outputChannel,
	// radio side
	input wire logic linkUp,
	input wire logic coordEncrypt,
	output logic [15:0] networkId,
	output logic [15:0] nodeAddr,
	output logic [swcd_pkg::CHAN_W-1:0] rfChannel,
	output logic [11:0] rfFreqMhz,
	output logic cipherEnable,
	output logic greenLed,
	// avalon-mm slave
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest
);
	// synchronised switches and channels
	wire [swcd_pkg::SW_W-1:0] swRaw = {rotarySw, addrSw, encSw, trigSw, modeSw};
	logic [swcd_pkg::SW_W-1:0] swStable; // filtered switch levels
	logic [CH-1:0] inStable; // filtered input channels
	logic [CH-1:0] inRise; // rising edge per input channel

	swcd_sync #(.W(swcd_pkg::SW_W)) uSwSync (
		.ref_clk(ref_clk),
		.rst(rst),
		.ce(ce),
		.din(swRaw),
		.stable(swStable),
		.riseEdge()
	);

	swcd_sync #(.W(CH)) uInSync (
		.ref_clk(ref_clk),
		.rst(rst),
		.ce(ce),
		.din(inputChannel),
		.stable(inStable),
		.riseEdge(inRise)
	);

	// start-up snapshot state
	logic [2:0] settleReg; // cycles since reset release
	logic cfgDoneReg; // snapshot taken, never retaken until reset
	logic [swcd_pkg::SW_W-1:0] cfgReg; // frozen switch settings
	wire settled = (settleReg == swcd_pkg::SETTLE_CYCLES);
	wire takeSnap = ce & settled & ~cfgDoneReg;

	// settle counter, then one snapshot; a switch moved later waits for power cycle
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			settleReg <= 3'h0;
			cfgDoneReg <= 1'b0;
			cfgReg <= '0;
		end else if (ce) begin
			if (!settled) begin
				settleReg <= settleReg + 3'h1;
			end
			if (takeSnap) begin
				cfgReg <= swStable; // RQ14
				cfgDoneReg <= 1'b1; // RQ14
			end
		end
	end

	// decoded snapshot fields
	wire setupMode = cfgReg[swcd_pkg::SW_MODE];
	wire pulseMode = cfgReg[swcd_pkg::SW_TRIG];
	wire encOn = cfgReg[swcd_pkg::SW_ENC];
	wire [swcd_pkg::ADDR_SW_W-1:0] addrCfg = cfgReg[swcd_pkg::SW_ADDR_HI:swcd_pkg::SW_ADDR_LO];
	wire [swcd_pkg::ROT_SW_W-1:0] rotCfg = cfgReg[swcd_pkg::SW_ROT_HI:swcd_pkg::SW_ROT_LO];

	// software-stored identity
	logic [15:0] storedIdReg;

	// identity and address selection
	wire [15:0] switchAddr = {{(16 - swcd_pkg::ADDR_SW_W){1'b0}}, addrCfg}; // RQ8
	wire [15:0] netIdNext = setupMode ? swcd_pkg::SETUP_NETID : storedIdReg; // RQ1 RQ2
	wire [15:0] addrNext = setupMode ? swcd_pkg::SETUP_ADDR : switchAddr; // RQ3
	wire isCoord = (addrNext == swcd_pkg::COORD_ADDR);
	// coordinator decides; the rest follow what the radio learned from it
	wire cipherNext = isCoord ? encOn : coordEncrypt; // RQ6 RQ7
	// rotary position in both modes; all nodes must share it, which is installer work
	wire [swcd_pkg::CHAN_W-1:0] chanNext =
		swcd_pkg::CHAN_BASE + {{(swcd_pkg::CHAN_W - swcd_pkg::ROT_SW_W){1'b0}}, rotCfg}; // RQ11
	wire [11:0] freqNext =
		swcd_pkg::FREQ_BASE_MHZ + 12'(swcd_pkg::FREQ_STEP_MHZ * {8'h00, rotCfg}); // RQ11

	// applied configuration registers; before the snapshot they decode an all-zero cfgReg and the stored identity
	logic [15:0] netIdReg;
	logic [15:0] addrReg;
	logic [swcd_pkg::CHAN_W-1:0] chanReg;
	logic [11:0] freqReg;
	logic cipherReg;
	logic ledReg;

	// applied values follow the snapshot and the stored identity
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			netIdReg <= swcd_pkg::NETID_RESET;
			addrReg <= swcd_pkg::COORD_ADDR;
			chanReg <= swcd_pkg::CHAN_BASE;
			freqReg <= swcd_pkg::FREQ_BASE_MHZ;
			cipherReg <= 1'b0;
			ledReg <= 1'b0;
		end else if (ce) begin
			netIdReg <= netIdNext; // RQ1 RQ2
			addrReg <= addrNext; // RQ3 RQ8
			chanReg <= chanNext; // RQ11
			freqReg <= freqNext; // RQ11
			cipherReg <= cfgDoneReg & cipherNext; // RQ6 RQ7
			// indicator only after configuration and an established link
			ledReg <= cfgDoneReg & linkUp; // RQ13
		end
	end

	// output channel logic
	logic [CH-1:0] outReg;
	wire anyHigh = |inStable;
	wire anyRise = |inRise;
	wire [CH-1:0] levelNext = {CH{anyHigh}};
	wire [CH-1:0] pulseNext = anyRise ? ~outReg : outReg;
	wire [CH-1:0] outNext = pulseMode ? pulseNext : levelNext;

	// outputs stay low until the trigger mode is known
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			outReg <= '0;
		end else if (ce && cfgDoneReg) begin
			outReg <= outNext; // RQ4 RQ5
		end
	end

	// avalon-mm slave: waitrequest drops on the second cycle of each access
	logic ackReg;
	logic [31:0] rdataReg;
	wire req = avs_read | avs_write;
	wire hitNetId = (avs_address == swcd_pkg::NETID_OFS);
	wire hitCfg = (avs_address == swcd_pkg::CONFIG_OFS);
	wire hitStatus = (avs_address == swcd_pkg::STATUS_OFS);
	wire hitIo = (avs_address == swcd_pkg::IO_OFS);
	wire wrNetId = ce & avs_write & ~ackReg & hitNetId;

	wire [31:0] cfgWord = {19'h00000, cfgDoneReg, cfgReg};
	wire [31:0] statusWord = {9'h000, ledReg, cipherReg, chanReg, addrReg};
	wire [31:0] ioWord = {{(16 - CH){1'b0}}, outReg, {(16 - CH){1'b0}}, inStable};
	// unmapped addresses read as zero and ignore writes
	wire [31:0] rdataNext = hitNetId ? {16'h0000, storedIdReg} :
		hitCfg ? cfgWord :
		hitStatus ? statusWord :
		hitIo ? ioWord : 32'h00000000;

	// stored identity, with byte enables; only two low lanes exist
	wire [15:0] idNext = {avs_byteenable[1] ? avs_writedata[15:8] : storedIdReg[15:8],
		avs_byteenable[0] ? avs_writedata[7:0] : storedIdReg[7:0]};

	// access handshake and register write
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			ackReg <= 1'b0;
			rdataReg <= 32'h00000000;
			storedIdReg <= swcd_pkg::NETID_RESET;
		end else if (ce) begin
			ackReg <= req & ~ackReg;
			if (avs_read && !ackReg) begin
				rdataReg <= rdataNext;
			end
			if (wrNetId) begin
				storedIdReg <= idNext; // RQ1
			end
		end
	end

	// port drive
	assign avs_waitrequest = req & ~ackReg;
	assign avs_readdata = rdataReg;
	assign outputChannel = outReg;
	assign networkId = netIdReg;
	assign nodeAddr = addrReg;
	assign rfChannel = chanReg;
	assign rfFreqMhz = freqReg;
	assign cipherEnable = cipherReg;
	assign greenLed = ledReg;

	// checks
	a_normal_netid: assert property (@(posedge ref_clk) disable iff (rst) // RQ1
		(ce && !setupMode) |=> (networkId == $past(storedIdReg)))
		else $error("normal mode identity not the stored one");

	a_setup_netid: assert property (@(posedge ref_clk) disable iff (rst) // RQ2
		(ce && cfgDoneReg && setupMode) |=> (networkId == 16'h3FFF))
		else $error("setup mode identity not forced");

	a_setup_addr: assert property (@(posedge ref_clk) disable iff (rst) // RQ3
		(ce && cfgDoneReg && setupMode) |=> (nodeAddr == 16'h0020))
		else $error("setup mode address not forced");

	a_level_high: assert property (@(posedge ref_clk) disable iff (rst) // RQ4
		(ce && cfgDoneReg && !pulseMode && anyHigh) |=> (&outputChannel))
		else $error("level mode output not all high");

	a_level_low: assert property (@(posedge ref_clk) disable iff (rst) // RQ4
		(ce && cfgDoneReg && !pulseMode && !anyHigh) |=> (outputChannel == '0))
		else $error("level mode output not all low");

	a_pulse_toggle: assert property (@(posedge ref_clk) disable iff (rst) // RQ5
		(ce && cfgDoneReg && pulseMode && anyRise)
		|=> (outputChannel == ~$past(outputChannel)))
		else $error("pulse mode output not inverted");

	a_pulse_hold: assert property (@(posedge ref_clk) disable iff (rst) // RQ5
		(cfgDoneReg && pulseMode && !(ce && anyRise)) |=> $stable(outputChannel))
		else $error("pulse mode output changed without edge");

	a_cipher_sel: assert property (@(posedge ref_clk) disable iff (rst) // RQ6
		(ce && cfgDoneReg) |=>
		(cipherEnable == ((nodeAddr == 16'h0000) ? $past(encOn) : $past(coordEncrypt))))
		else $error("cipher selection wrong");

	a_coord_rules: assert property (@(posedge ref_clk) disable iff (rst) // RQ7
		(ce && cfgDoneReg && !setupMode && (addrCfg != 5'h00)) |=>
		(cipherEnable == $past(coordEncrypt)))
		else $error("follower did not adopt coordinator setting");

	a_addr_bits: assert property (@(posedge ref_clk) disable iff (rst) // RQ8
		(ce && !setupMode) |=> (nodeAddr == {11'h000, $past(addrCfg)}))
		else $error("address not taken from switches");

	a_freq_map: assert property (@(posedge ref_clk) disable iff (rst) // RQ11
		(ce && cfgDoneReg) |=> (rfFreqMhz == 12'd2405 + 12'd5 * {8'h00, $past(rotCfg)}))
		else $error("rotary to frequency map wrong");

	a_led_link: assert property (@(posedge ref_clk) disable iff (rst) // RQ13
		(ce && !(linkUp && cfgDoneReg)) |=> !greenLed)
		else $error("indicator lit without link");

	a_cfg_frozen: assert property (@(posedge ref_clk) disable iff (rst) // RQ14
		cfgDoneReg |=> ($stable(cfgReg) && cfgDoneReg))
		else $error("switch snapshot changed after start-up");

	a_bus_answer: assert property (@(posedge ref_clk) disable iff (rst)
		(ce && req && !ackReg) |=> (!avs_waitrequest || !req))
		else $error("bus access not answered on second cycle");
endmodule : swcd_top

// ===== swcd_pkg.sv
// Purpose: shared constants for the setting-switch configuration decoder
// Assumes: registers sit on a 32-bit Avalon-MM slave, byte addressed
// Notes: every offset, field position, forced identity and switch width lives here; the channel count CH is a parameter of swcd_top
package swcd_pkg;
	// register byte offsets
	localparam logic [3:0] NETID_OFS = 4'h0; // stored network identity, read/write
	localparam logic [3:0] CONFIG_OFS = 4'h4; // switch snapshot, read only
	localparam logic [3:0] STATUS_OFS = 4'h8; // applied node address, channel, cipher and link state
	localparam logic [3:0] IO_OFS = 4'hC; // input channels and output channels

	// reset and forced identities
	localparam logic [15:0] NETID_RESET = 16'h0000; // software identity after reset
	localparam logic [15:0] SETUP_NETID = 16'h3FFF; // identity forced in setup mode
	localparam logic [15:0] SETUP_ADDR = 16'h0020; // node address forced in setup mode
	localparam logic [15:0] COORD_ADDR = 16'h0000; // coordinator node address

	// switch widths
	localparam int ADDR_SW_W = 5; // node address switches
	localparam int ROT_SW_W = 4; // rotary channel switch
	localparam int SW_W = 3 + ADDR_SW_W + ROT_SW_W; // all switches as one vector

	// positions of each switch in the synchronised switch vector
	localparam int SW_MODE = 0; // start-up mode, on = setup
	localparam int SW_TRIG = 1; // trigger mode, on = pulse
	localparam int SW_ENC = 2; // encryption, on = enabled
	localparam int SW_ADDR_LO = 3; // last address switch, lsb
	localparam int SW_ADDR_HI = SW_ADDR_LO + ADDR_SW_W - 1; // first address switch, msb
	localparam int SW_ROT_LO = SW_ADDR_HI + 1; // rotary lsb
	localparam int SW_ROT_HI = SW_ROT_LO + ROT_SW_W - 1; // rotary msb

	// config register fields
	localparam int CFG_DONE_BIT = 12; // switches have been sampled

	// status register fields
	localparam int ST_ADDR_LO = 0; // applied node address
	localparam int ST_CHAN_LO = 16; // radio channel number
	localparam int ST_CIPHER_BIT = 21; // encryption in force
	localparam int ST_LED_BIT = 22; // link indicator
	localparam int CHAN_W = 5; // radio channel number width

	// io register fields
	localparam int IO_OUT_LO = 16; // output channels start here

	// radio channel map: channel = base + position, frequency = base + step * position
	localparam logic [4:0] CHAN_BASE = 5'h0B; // first channel number of the band
	localparam logic [11:0] FREQ_BASE_MHZ = 12'h965; // lowest centre frequency in MHz
	localparam logic [11:0] FREQ_STEP_MHZ = 12'h005; // channel spacing in MHz

	// start-up settling
	localparam logic [2:0] SETTLE_CYCLES = 3'h4; // sync chain depth plus stable stage
endpackage : swcd_pkg

// ===== swcd_sync.sv
// Purpose: three-flop synchroniser with agreement filter, one lane per bit
// Assumes: din is asynchronous to ref_clk
// Notes: a change counts only once the second and third stages agree
`timescale 1ns/100ps
module swcd_sync #(
	parameter int W = 8
) (
	// clock, reset, enable
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic ce,
	// raw pins
	input wire logic [W-1:0] din,
	// filtered level and its rising edge
	output logic [W-1:0] stable,
	output logic [W-1:0] riseEdge
);
	genvar i;
	generate
		for (i = 0; i < W; i++) begin : g_lane
			logic s1Reg; // first stage, read only by the second
			logic s2Reg; // second stage
			logic s3Reg; // third stage
			logic stableReg; // accepted level
			wire agree = (s2Reg == s3Reg); // second and third agree
			// shift chain; the stable stage only follows an agreed value
			always_ff @(posedge ref_clk) begin
				if (rst) begin
					s1Reg <= 1'b0;
					s2Reg <= 1'b0;
					s3Reg <= 1'b0;
					stableReg <= 1'b0;
				end else if (ce) begin
					s1Reg <= din[i];
					s2Reg <= s1Reg;
					s3Reg <= s2Reg;
					if (agree) begin
						stableReg <= s3Reg;
					end
				end
			end
			assign stable[i] = stableReg;
			// edge is flagged in the cycle before stable rises
			assign riseEdge[i] = ce & agree & s3Reg & ~stableReg;
		end
	endgenerate
endmodule : swcd_sync

// ===== swcd_radio_peer.sv
// Purpose: model of the radio network seen from the decoder: link state, coordinator cipher
// Assumes: exactly one coordinator at node 0 and one shared rotary position network-wide
// Notes: the link forms a fixed number of cycles after reset release
`timescale 1ns/100ps
module swcd_radio_peer #(
	parameter int LINK_DELAY = 30 // cycles until the network forms
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// the coordinator's own encryption switch
	input wire logic coordSetting,
	// link state and learned cipher setting
	output logic linkUp,
	output logic coordEncrypt
);
	logic [7:0] waitCnt_reg; // cycles since reset release

	// one coordinator on one channel, so the join always succeeds after the delay
	// every node has its own switch address, so no duplicate joins
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			waitCnt_reg <= 8'h00;
			linkUp <= 1'b0;
		end else if (waitCnt_reg != 8'(LINK_DELAY)) begin
			waitCnt_reg <= waitCnt_reg + 8'h01;
		end else begin
			linkUp <= 1'b1;
		end
	end

	// followers only learn the setting over a formed link, never before
	assign coordEncrypt = linkUp & coordSetting;
endmodule : swcd_radio_peer

// ===== tb_switch_config_decoder.sv
// Purpose: self-checking bench for the setting-switch decoder
// Assumes: one wait state on the register bus, snapshot ready 12 cycles after reset
// Notes: every switch case needs its own reset, since switches are sampled once
`timescale 1ns/100ps
module tb_switch_config_decoder;
	logic ref_clk = 1'b0, rst = 1'b1, ce = 1'b1; // clock, reset, enable
	logic modeSw = 1'b0, trigSw = 1'b0, encSw = 1'b0, coordSetting = 1'b0; // switches
	logic [4:0] addrSw = 5'h00; // address switches
	logic [3:0] rotarySw = 4'h0; // rotary switch
	logic [7:0] inputChannel = 8'h00, outputChannel; // field channels
	logic linkUp, coordEncrypt, cipherEnable, greenLed; // radio side
	logic [15:0] networkId, nodeAddr; // applied identity
	logic [4:0] rfChannel; // channel number
	logic [11:0] rfFreqMhz; // centre frequency
	logic [3:0] avs_address = 4'h0, avs_byteenable = 4'hF; // bus address, lanes
	logic avs_read = 1'b0, avs_write = 1'b0, avs_waitrequest; // bus strobes
	logic [31:0] avs_writedata = 32'h0, avs_readdata, rd; // bus data
	int num_errors = 0, compares = 0; // verdict counters

	swcd_top #(.CH(8)) uut (.ref_clk(ref_clk), .rst(rst), .ce(ce), .modeSw(modeSw),
		.trigSw(trigSw), .encSw(encSw), .addrSw(addrSw), .rotarySw(rotarySw),
		.inputChannel(inputChannel), .outputChannel(outputChannel), .linkUp(linkUp),
		.coordEncrypt(coordEncrypt), .networkId(networkId), .nodeAddr(nodeAddr),
		.rfChannel(rfChannel), .rfFreqMhz(rfFreqMhz), .cipherEnable(cipherEnable),
		.greenLed(greenLed), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest));
	swcd_radio_peer #(.LINK_DELAY(30)) peer (.ref_clk(ref_clk), .rst(rst),
		.coordSetting(coordSetting), .linkUp(linkUp), .coordEncrypt(coordEncrypt));

	// 250 MHz clock
	initial begin
		forever #2 ref_clk = ~ref_clk;
	end

	// compare one value and count it
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			num_errors++;
			$display("unexpected %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk

	// one bus access, held until waitrequest is seen low at a rising edge
	task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] wd,
		input logic [3:0] be);
		int n;
		n = 0;
		@(posedge ref_clk);
		avs_address <= a;
		avs_writedata <= wd;
		avs_byteenable <= be;
		avs_read <= ~wr;
		avs_write <= wr;
		// sample at each rising edge; the edge that sees waitrequest low completes it
		do begin
			@(posedge ref_clk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 50);
		if (n >= 50) chk("waitrequest", 1, 0);
		rd = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask : bus

	// power-up with a switch setting, then wait for the snapshot to apply
	task automatic boot(input logic m, input logic t, input logic e, input logic [4:0] a,
		input logic [3:0] r);
		@(posedge ref_clk);
		{modeSw, trigSw, encSw, addrSw, rotarySw} <= {m, t, e, a, r};
		rst <= 1'b1;
		repeat (20) @(posedge ref_clk);
		rst <= 1'b0;
		repeat (12) @(posedge ref_clk);
	endtask : boot

	// all rotary positions, coordinator and follower cipher, address order, indicator
	task automatic t_channels;
		logic [4:0] a;
		for (int r = 0; r < 16; r++) begin
			a = r[0] ? 5'h00 : {1'b1, r[3:0]};
			coordSetting <= r[2];
			boot(1'b0, 1'b0, r[1], a, r[3:0]);
			chk("led early", greenLed, 0);
			chk("channel", rfChannel, swcd_pkg::CHAN_BASE + 5'(r));
			chk("freq", rfFreqMhz, swcd_pkg::FREQ_BASE_MHZ + 12'(5 * r));
			chk("addr", nodeAddr, {11'h0, a});
			repeat (40) @(posedge ref_clk);
			chk("led", greenLed, 1);
			chk("cipher", cipherEnable, r[0] ? r[1] : r[2]);
		end
		$display("test channels done");
	endtask : t_channels

	// normal mode: stored identity through the bus, switches frozen after boot
	task automatic t_normal;
		boot(1'b0, 1'b1, 1'b1, 5'h13, 4'h9);
		chk("netid reset", networkId, 0);
		bus(1'b1, swcd_pkg::NETID_OFS, 32'h5555ABCD, 4'hF);
		bus(1'b1, swcd_pkg::NETID_OFS, 32'h00000012, 4'h1);
		bus(1'b0, swcd_pkg::NETID_OFS, 32'h0, 4'hF);
		chk("netid rd", rd, 32'h0000AB12);
		chk("netid", networkId, 16'hAB12);
		bus(1'b0, swcd_pkg::CONFIG_OFS, 32'h0, 4'hF);
		chk("config", rd, 32'h0000199E);
		bus(1'b1, swcd_pkg::CONFIG_OFS, 32'hFFFFFFFF, 4'hF);
		bus(1'b0, swcd_pkg::CONFIG_OFS, 32'h0, 4'hF);
		chk("config ro", rd, 32'h0000199E);
		bus(1'b0, 4'h2, 32'h0, 4'hF);
		chk("unmapped", rd, 0);
		addrSw <= 5'h02;
		modeSw <= 1'b1;
		repeat (10) @(posedge ref_clk);
		chk("frozen addr", nodeAddr, 16'h0013);
		chk("frozen id", networkId, 16'hAB12);
		$display("test normal done");
	endtask : t_normal

	// setup mode forces identity and address, rotary still applies
	task automatic t_setup;
		coordSetting <= 1'b0;
		boot(1'b1, 1'b0, 1'b0, 5'h1F, 4'h4);
		chk("setup id", networkId, swcd_pkg::SETUP_NETID);
		chk("setup addr", nodeAddr, swcd_pkg::SETUP_ADDR);
		chk("setup chan", rfChannel, swcd_pkg::CHAN_BASE + 5'h04);
		// once the link is up: indicator set, follower cipher off, address and channel
		repeat (40) @(posedge ref_clk);
		bus(1'b0, swcd_pkg::STATUS_OFS, 32'h0, 4'hF);
		chk("status", rd, 32'h004F0020);
		$display("test setup done");
	endtask : t_setup

	// level mode follows the OR of the inputs
	task automatic t_level;
		boot(1'b0, 1'b0, 1'b0, 5'h01, 4'h0);
		inputChannel <= 8'h08;
		repeat (8) @(posedge ref_clk);
		chk("level hi", outputChannel, 8'hFF);
		bus(1'b0, swcd_pkg::IO_OFS, 32'h0, 4'hF);
		chk("io word", rd, 32'h00FF0008);
		inputChannel <= 8'h00;
		repeat (8) @(posedge ref_clk);
		chk("level lo", outputChannel, 8'h00);
		$display("test level done");
	endtask : t_level

	// pulse mode: simultaneous rises invert once, falls do nothing
	task automatic t_pulse;
		boot(1'b0, 1'b1, 1'b0, 5'h01, 4'h0);
		chk("pulse idle", outputChannel, 8'h00);
		inputChannel <= 8'h21;
		repeat (16) @(posedge ref_clk);
		chk("pulse one", outputChannel, 8'hFF);
		inputChannel <= 8'h00;
		repeat (8) @(posedge ref_clk);
		chk("pulse fall", outputChannel, 8'hFF);
		inputChannel <= 8'h80;
		repeat (8) @(posedge ref_clk);
		chk("pulse two", outputChannel, 8'h00);
		// enable low freezes the chain; the new rise acts once enable returns
		ce <= 1'b0;
		inputChannel <= 8'h01;
		repeat (8) @(posedge ref_clk);
		chk("pulse frozen", outputChannel, 8'h00);
		ce <= 1'b1;
		repeat (8) @(posedge ref_clk);
		chk("pulse resume", outputChannel, 8'hFF);
		$display("test pulse done");
	endtask : t_pulse

	// print counts and the verdict, then stop
	task automatic conclude;
		$display("compares %0d errors %0d", compares, num_errors);
		if (num_errors == 0 && compares > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : conclude

	// watchdog well beyond the roughly 1450 cycles the tests need
	initial begin
		repeat (20000) @(posedge ref_clk);
		num_errors++;
		conclude();
	end

	// main sequence
	initial begin
		t_channels();
		t_normal();
		t_setup();
		t_level();
		t_pulse();
		conclude();
	end
endmodule : tb_switch_config_decoder
